// ===== inc/ctw_pkg.sv
// constants shared by the clock, timer and watchdog block
`default_nettype none
package ctw_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CORE_STATUS   = 6'h04;
    localparam logic [5:0] IDX_IRQ_FLAGS     = 6'h06;
    localparam logic [5:0] IDX_IRQ_ENABLES   = 6'h07;
    localparam logic [5:0] IDX_DOG_CONTROL   = 6'h0D;
    localparam logic [5:0] IDX_TIMER_COUNT   = 6'h0E;
    localparam logic [5:0] IDX_TIMER_CONTROL = 6'h0F;
    localparam logic [5:0] IDX_MAIN_CLK_SEL  = 6'h14;
    localparam logic [5:0] IDX_PERIPH_CLK_SEL = 6'h15;

    // field positions
    localparam int BIT_POWERDOWN   = 4;
    localparam int BIT_TIMEOUT     = 3;
    localparam int BIT_TIMER_IRQ   = 4;
    localparam int BIT_GLOBAL_IRQ  = 7;
    localparam int BIT_DOG_ENABLE  = 7;
    localparam int BIT_TIMER_CLEAR = 7;
    localparam int BIT_COUNTER_RUN = 3;
    localparam int BIT_SPLIT_SEL   = 2;
    localparam int BIT_QUARTER_SEL = 1;
    localparam int BIT_CHOPPER_LO  = 2;
    localparam int BIT_BEEPER_SEL  = 1;

    // values after reset
    localparam logic [7:0] RST_IRQ_ENABLES  = 8'h00;
    localparam logic [7:0] RST_TIMER_COUNT  = 8'h00;
    localparam logic [2:0] RST_TAP_SEL      = 3'h0;
    localparam logic [1:0] RST_CHOPPER_SEL  = 2'h0;

    // division counts in main clock cycles; chopper half periods in CLK cycles
    localparam int INSTR_DIV_FAST = 2;
    localparam int INSTR_DIV_SLOW = 4;
    localparam int CLK_QUARTER_DIV = 4;
    localparam logic [7:0] FRAC_STEP     = 8'h07;
    localparam logic [7:0] FRAC_MOD_FAST = 8'h32;
    localparam logic [7:0] FRAC_MOD_SLOW = 8'h64;
    localparam int ADC_DIV_FAST    = 100;
    localparam int ADC_DIV_SLOW    = 200;
    localparam int CHOP_HALF_FAST  = 1000;
    localparam int CHOP_HALF_SLOW  = 2000;
    localparam int BEEP_HALF_FAST  = 256;
    localparam int BEEP_HALF_SLOW  = 512;
    localparam int TICK_DIV        = 1024;

    // watchdog oscillator, made from the reference clock
    localparam int REF_CLK_HZ      = 100_000_000;
    localparam int DOG_OSC_HZ      = 12_000;
    localparam int DOG_OSC_DIV     = REF_CLK_HZ / DOG_OSC_HZ;
endpackage
`default_nettype wire

// ===== design/ctw_clock_timer_watchdog.sv
// clock divider network, 8-bit timer and watchdog
`default_nettype none
module ctw_clock_timer_watchdog
    import ctw_pkg::*;
#(
    parameter int DOG_OSC_CYCLES = DOG_OSC_DIV
)(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // core side
    input  wire logic       core_sleep,
    input  wire logic       dog_kick_instruction,
    input  wire logic       modulator_on,
    output logic            irq_req,
    output logic            dog_timeout_pulse,
    // derived clocks
    output logic            main_clock_en,
    output logic            instr_clock_en,
    output logic            adc_sample_clock,
    output logic            timer_tick_clock,
    output logic            chopper_clock,
    output logic            beeper_clock,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata
);

    if (DOG_OSC_CYCLES < 2 || DOG_OSC_CYCLES > 16383)
    begin
        $error("DOG_OSC_CYCLES out of range");
    end

    // register decode, only aligned words are mapped
    logic       addr_ok;
    logic [5:0] addr_idx;
    assign addr_ok  = (reg_addr[1:0] == 2'h0);
    assign addr_idx = reg_addr[7:2];

    logic wr_status, wr_flags, wr_enables, wr_dog, wr_tctl, wr_mck, wr_pck;
    assign wr_status  = reg_wr && addr_ok && (addr_idx == IDX_CORE_STATUS);
    assign wr_flags   = reg_wr && addr_ok && (addr_idx == IDX_IRQ_FLAGS);
    assign wr_enables = reg_wr && addr_ok && (addr_idx == IDX_IRQ_ENABLES);
    assign wr_dog     = reg_wr && addr_ok && (addr_idx == IDX_DOG_CONTROL);
    assign wr_tctl    = reg_wr && addr_ok && (addr_idx == IDX_TIMER_CONTROL);
    assign wr_mck     = reg_wr && addr_ok && (addr_idx == IDX_MAIN_CLK_SEL);
    assign wr_pck     = reg_wr && addr_ok && (addr_idx == IDX_PERIPH_CLK_SEL);

    // control registers
    logic [7:0] irq_enables_r;
    logic       dog_enable_r;
    logic [2:0] dog_tap_sel_r;
    logic       counter_run_r;
    logic [2:0] tick_tap_sel_r;
    logic       cpu_adc_split_sel_r;
    logic       quarter_rate_sel_r;
    logic [1:0] chopper_clock_sel_r;
    logic       beeper_sel_r;

    // plain read/write selects
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_enables_r       <= RST_IRQ_ENABLES;
            tick_tap_sel_r      <= RST_TAP_SEL;
            counter_run_r       <= 1'b0;
            cpu_adc_split_sel_r <= 1'b0;
            quarter_rate_sel_r  <= 1'b0;
            chopper_clock_sel_r <= RST_CHOPPER_SEL;
            beeper_sel_r        <= 1'b0;
        end
        else
        begin
            if (wr_enables)
                irq_enables_r <= reg_wdata;
            if (wr_tctl)
            begin
                counter_run_r  <= reg_wdata[BIT_COUNTER_RUN];
                tick_tap_sel_r <= reg_wdata[2:0];
            end
            if (wr_mck)
            begin
                cpu_adc_split_sel_r <= reg_wdata[BIT_SPLIT_SEL];
                quarter_rate_sel_r  <= reg_wdata[BIT_QUARTER_SEL];
            end
            if (wr_pck)
            begin
                chopper_clock_sel_r <= reg_wdata[BIT_CHOPPER_LO+1:BIT_CHOPPER_LO];
                beeper_sel_r        <= reg_wdata[BIT_BEEPER_SEL];
            end
        end
    end

    // dog enable is sticky: a zero write cannot stop it
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dog_enable_r  <= 1'b0;
            dog_tap_sel_r <= RST_TAP_SEL;
        end
        else if (wr_dog)
        begin
            if (reg_wdata[BIT_DOG_ENABLE])
                dog_enable_r <= 1'b1;
            dog_tap_sel_r <= reg_wdata[2:0];
        end
    end

    // main clock gate; the core owns the sleep level
    assign main_clock_en = !core_sleep;

    // powerdown flag, set on entry to sleep; set beats a clear
    logic sleep_d_r;
    logic powerdown_flag_r;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sleep_d_r        <= 1'b0;
            powerdown_flag_r <= 1'b0;
        end
        else
        begin
            sleep_d_r <= core_sleep;
            if (core_sleep && !sleep_d_r)
                powerdown_flag_r <= 1'b1;
            else if (wr_status && !reg_wdata[BIT_POWERDOWN])
                powerdown_flag_r <= 1'b0;
        end
    end

    // CLK: main clock, or one in four when the quarter bit is set
    logic [1:0] quarter_cnt_r;
    logic       clk_en;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            quarter_cnt_r <= 2'h0;
        else if (main_clock_en)
            quarter_cnt_r <= quarter_cnt_r + 2'h1;
    end
    assign clk_en = main_clock_en &&
                    (!quarter_rate_sel_r || (quarter_cnt_r == 2'(CLK_QUARTER_DIV - 1)));

    // instruction clock: integer path, plus fractional path that
    // keeps CPU activity out of step with the ADC sample grid
    logic       frac_mode;
    logic [1:0] instr_cnt_r;
    logic [1:0] instr_top;
    logic [7:0] frac_acc_r;
    logic [7:0] frac_sum;
    logic [7:0] frac_mod;
    assign frac_mode = modulator_on && !cpu_adc_split_sel_r;
    assign instr_top = quarter_rate_sel_r ? 2'(INSTR_DIV_SLOW - 1) : 2'(INSTR_DIV_FAST - 1);
    assign frac_mod  = quarter_rate_sel_r ? FRAC_MOD_SLOW : FRAC_MOD_FAST;
    assign frac_sum  = frac_acc_r + FRAC_STEP;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            instr_cnt_r    <= 2'h0;
            frac_acc_r     <= 8'h00;
            instr_clock_en <= 1'b0;
        end
        else if (!main_clock_en)
            instr_clock_en <= 1'b0;
        else if (frac_mode)
        begin
            // average period 50/7 or 100/7 main clocks
            instr_cnt_r <= 2'h0;
            if (frac_sum >= frac_mod)
            begin
                frac_acc_r     <= frac_sum - frac_mod;
                instr_clock_en <= 1'b1;
            end
            else
            begin
                frac_acc_r     <= frac_sum;
                instr_clock_en <= 1'b0;
            end
        end
        else
        begin
            frac_acc_r <= 8'h00;
            if (instr_cnt_r >= instr_top)
            begin
                instr_cnt_r    <= 2'h0;
                instr_clock_en <= 1'b1;
            end
            else
            begin
                instr_cnt_r    <= instr_cnt_r + 2'h1;
                instr_clock_en <= 1'b0;
            end
        end
    end

    // ADC sample clock, one pulse per period
    logic [7:0] adc_cnt_r;
    logic [7:0] adc_top;
    assign adc_top = quarter_rate_sel_r ? 8'(ADC_DIV_SLOW - 1) : 8'(ADC_DIV_FAST - 1);
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            adc_cnt_r        <= 8'h00;
            adc_sample_clock <= 1'b0;
        end
        else if (!main_clock_en)
            adc_sample_clock <= 1'b0;
        else if (adc_cnt_r >= adc_top)
        begin
            adc_cnt_r        <= 8'h00;
            adc_sample_clock <= 1'b1;
        end
        else
        begin
            adc_cnt_r        <= adc_cnt_r + 8'h01;
            adc_sample_clock <= 1'b0;
        end
    end

    // chopper square wave counted in CLK cycles
    logic [10:0] chop_cnt_r;
    logic [10:0] chop_top;
    logic        chop_wave_r;
    assign chop_top = chopper_clock_sel_r[0] ? 11'(CHOP_HALF_SLOW - 1)
                                             : 11'(CHOP_HALF_FAST - 1);
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            chop_cnt_r  <= 11'h000;
            chop_wave_r <= 1'b0;
        end
        else if (!chopper_clock_sel_r[1])
        begin
            chop_cnt_r  <= 11'h000;
            chop_wave_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (chop_cnt_r >= chop_top)
            begin
                chop_cnt_r  <= 11'h000;
                chop_wave_r <= !chop_wave_r;
            end
            else
                chop_cnt_r <= chop_cnt_r + 11'h001;
        end
    end

    // static codes give a constant level
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            chopper_clock <= 1'b0;
        else
        begin
            case (chopper_clock_sel_r)
                2'h0:    chopper_clock <= 1'b0;
                2'h1:    chopper_clock <= 1'b1;
                default: chopper_clock <= chop_wave_r;
            endcase
        end
    end

    // beeper square wave, held while the main clock is stopped
    logic [8:0] beep_cnt_r;
    logic [8:0] beep_top;
    assign beep_top = beeper_sel_r ? 9'(BEEP_HALF_SLOW - 1) : 9'(BEEP_HALF_FAST - 1);
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            beep_cnt_r   <= 9'h000;
            beeper_clock <= 1'b0;
        end
        else if (main_clock_en)
        begin
            if (beep_cnt_r >= beep_top)
            begin
                beep_cnt_r   <= 9'h000;
                beeper_clock <= !beeper_clock;
            end
            else
                beep_cnt_r <= beep_cnt_r + 9'h001;
        end
    end

    // timer tick, one pulse every 1024 main clocks
    logic [9:0] tick_cnt_r;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_r       <= 10'h000;
            timer_tick_clock <= 1'b0;
        end
        else if (main_clock_en)
        begin
            tick_cnt_r       <= tick_cnt_r + 10'h001;
            timer_tick_clock <= (tick_cnt_r == 10'(TICK_DIV - 1));
        end
        else
            timer_tick_clock <= 1'b0;
    end

    // 8-bit counter; the clear pulse beats an advance
    logic       timer_clear;
    logic [7:0] counter_value_r;
    logic [7:0] counter_next;
    logic       timer_event;
    assign timer_clear  = wr_tctl && !reg_wdata[BIT_TIMER_CLEAR];
    assign counter_next = counter_value_r + 8'h01;
    // event on the falling edge of the selected counter bit
    assign timer_event  = timer_tick_clock && counter_run_r && !timer_clear &&
                          counter_value_r[tick_tap_sel_r] &&
                          !counter_next[tick_tap_sel_r];

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            counter_value_r <= RST_TIMER_COUNT;
        else if (timer_clear)
            counter_value_r <= 8'h00;
        else if (timer_tick_clock && counter_run_r)
            counter_value_r <= counter_next;
    end

    // timer flag; a new event beats a software clear
    logic timer_irq_flag_r;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            timer_irq_flag_r <= 1'b0;
        else if (timer_event)
            timer_irq_flag_r <= 1'b1;
        else if (wr_flags && !reg_wdata[BIT_TIMER_IRQ])
            timer_irq_flag_r <= 1'b0;
    end

    assign irq_req = timer_irq_flag_r && irq_enables_r[BIT_TIMER_IRQ] &&
                     irq_enables_r[BIT_GLOBAL_IRQ];

    // watchdog oscillator stand-in; runs through sleep
    logic [13:0] dog_osc_cnt_r;
    logic        dog_osc_tick;
    assign dog_osc_tick = dog_enable_r && (dog_osc_cnt_r == 14'(DOG_OSC_CYCLES - 1));
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            dog_osc_cnt_r <= 14'h0000;
        else if (!dog_enable_r || dog_osc_tick)
            dog_osc_cnt_r <= 14'h0000;
        else
            dog_osc_cnt_r <= dog_osc_cnt_r + 14'h0001;
    end

    // prescaler and second counter
    logic [7:0] dog_prescaler_r;
    logic [7:0] dog_pre_next;
    logic [2:0] dog_tap_bit;
    logic       dog_step;
    logic [7:0] dog_count2_r;
    logic       dog_overflow;
    assign dog_pre_next = dog_prescaler_r + 8'h01;
    assign dog_tap_bit  = 3'h7 - dog_tap_sel_r;
    assign dog_step     = dog_osc_tick && dog_prescaler_r[dog_tap_bit] &&
                          !dog_pre_next[dog_tap_bit];
    assign dog_overflow = dog_step && !dog_kick_instruction && (dog_count2_r == 8'hFF);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            dog_prescaler_r <= 8'h00;
        else if (dog_osc_tick)
            dog_prescaler_r <= dog_pre_next;
    end

    // kick wins over a step in the same cycle
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            dog_count2_r <= 8'h00;
        else if (dog_kick_instruction)
            dog_count2_r <= 8'h00;
        else if (dog_step)
            dog_count2_r <= dog_count2_r + 8'h01;
    end

    // timeout pulse and sticky flag; timeout beats a clear
    logic timeout_flag_r;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dog_timeout_pulse <= 1'b0;
            timeout_flag_r    <= 1'b0;
        end
        else
        begin
            dog_timeout_pulse <= dog_overflow;
            if (dog_overflow)
                timeout_flag_r <= 1'b1;
            else if (wr_status && !reg_wdata[BIT_TIMEOUT])
                timeout_flag_r <= 1'b0;
        end
    end

    // read mux; unmapped and reserved bits read zero
    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        if (addr_ok)
        begin
            case (addr_idx)
                IDX_CORE_STATUS:
                begin
                    rd_mux[BIT_POWERDOWN] = powerdown_flag_r;
                    rd_mux[BIT_TIMEOUT]   = timeout_flag_r;
                end
                IDX_IRQ_FLAGS:   rd_mux[BIT_TIMER_IRQ] = timer_irq_flag_r;
                IDX_IRQ_ENABLES: rd_mux = irq_enables_r;
                IDX_DOG_CONTROL:
                begin
                    rd_mux[BIT_DOG_ENABLE] = dog_enable_r;
                    rd_mux[2:0]            = dog_tap_sel_r;
                end
                IDX_TIMER_COUNT: rd_mux = counter_value_r;
                IDX_TIMER_CONTROL:
                begin
                    rd_mux[BIT_TIMER_CLEAR] = 1'b1;
                    rd_mux[BIT_COUNTER_RUN] = counter_run_r;
                    rd_mux[2:0]             = tick_tap_sel_r;
                end
                IDX_MAIN_CLK_SEL:
                begin
                    rd_mux[BIT_SPLIT_SEL]   = cpu_adc_split_sel_r;
                    rd_mux[BIT_QUARTER_SEL] = quarter_rate_sel_r;
                end
                IDX_PERIPH_CLK_SEL:
                begin
                    rd_mux[BIT_CHOPPER_LO+1:BIT_CHOPPER_LO] = chopper_clock_sel_r;
                    rd_mux[BIT_BEEPER_SEL]                  = beeper_sel_r;
                end
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // read data stands one cycle after each cycle of reg_rd, zero otherwise
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end

endmodule
`default_nettype wire

// ===== testbench/ctw_props.sv
// checker watching the ports of the clock, timer and watchdog block
`default_nettype none
module ctw_props
    import ctw_pkg::*;
#(
    parameter int DOG_OSC_CYCLES = 2
)(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       nrst,
    // core side
    input wire logic       core_sleep,
    input wire logic       dog_kick_instruction,
    input wire logic       modulator_on,
    input wire logic       irq_req,
    input wire logic       dog_timeout_pulse,
    // derived clocks
    input wire logic       main_clock_en,
    input wire logic       instr_clock_en,
    input wire logic       adc_sample_clock,
    input wire logic       timer_tick_clock,
    input wire logic       chopper_clock,
    input wire logic       beeper_clock,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] en_r;
    logic [7:0] psel_r;
    logic [9:0] gap_r;
    logic       slp_r;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // shadow copies of written enables and peripheral selects
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            en_r   <= 8'h00;
            psel_r <= 8'h00;
        end
        else if (reg_wr && reg_addr == 8'h1C)
            en_r <= reg_wdata;
        else if (reg_wr && reg_addr == 8'h54)
            psel_r <= reg_wdata;
    end
    // tick spacing; an interval touched by sleep is not judged
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_r <= 10'h000;
            slp_r <= 1'b1;
        end
        else
        begin
            gap_r <= timer_tick_clock ? 10'h000 : gap_r + 10'h001;
            slp_r <= timer_tick_clock ? core_sleep : (slp_r | core_sleep);
        end
    end
    chk_sleep_gate: assert property (main_clock_en == !core_sleep)
        else $error("main clock enable does not follow sleep");
    chk_clock_stop: assert property (core_sleep [*2] |->
        !(instr_clock_en | adc_sample_clock | timer_tick_clock))
        else $error("derived clock pulse while asleep");
    chk_instr_gap: assert property (instr_clock_en |=> !instr_clock_en)
        else $error("instruction pulses back to back");
    chk_tick_period: assert property (timer_tick_clock && !slp_r |-> gap_r == 10'h3FF)
        else $error("tick spacing not 1024 cycles");
    chk_beep_hold: assert property ($changed(beeper_clock) |=> $stable(beeper_clock) [*8])
        else $error("beeper half period too short");
    chk_chop_level: assert property (!psel_r[3] && $past(psel_r[3:2]) == psel_r[3:2]
        |-> chopper_clock == psel_r[2])
        else $error("chopper level wrong");
    chk_irq_gate: assert property (irq_req |-> en_r[7] && en_r[4])
        else $error("request without both enables");
    chk_ctl_read: assert property (reg_rd && reg_addr == 8'h3C |=> reg_rdata[7])
        else $error("clear bit does not read one");
    chk_dog_single: assert property (dog_timeout_pulse |=> !dog_timeout_pulse)
        else $error("timeout pulse longer than a cycle");
    chk_kick_clear: assert property (dog_kick_instruction |-> ##2 !dog_timeout_pulse [*8])
        else $error("timeout right after a kick");
    cover property (dog_timeout_pulse);
    cover property (irq_req);
    cover property (core_sleep [*2]);
endmodule
bind ctw_clock_timer_watchdog ctw_props #(.DOG_OSC_CYCLES(DOG_OSC_CYCLES)) u_props (.*);
`default_nettype wire

// ===== testbench/ctw_core_model.sv
// behavioural core that sleeps and issues watchdog kicks
`default_nettype none
module ctw_core_model
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // bench requests
    input  wire logic sleep_req,
    input  wire logic kick_req,
    // instructions to the block
    output var logic  core_sleep,
    output var logic  dog_kick_instruction
);
    timeunit 1ns;
    timeprecision 1ps;
    logic kick_q;
    // one kick instruction per request, sleep follows the request
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            core_sleep           <= 1'b0;
            dog_kick_instruction <= 1'b0;
            kick_q               <= 1'b0;
        end
        else
        begin
            core_sleep           <= sleep_req;
            dog_kick_instruction <= kick_req & ~kick_q;
            kick_q               <= kick_req;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/clock_timer_watchdog_test.sv
// self-checking bench for the clock, timer and watchdog block
`default_nettype none
module clock_timer_watchdog_test
    import ctw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DOGC = 2;
    // rows: main select, peripheral select, modulator, event, window, count
    int         ms_t [12] = '{0, 2, 4, 6, 0, 2, 0, 2, 0, 0, 0, 0};
    int         ps_t [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 8, 12};
    int         md_t [12] = '{0, 0, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0};
    int         ev_t [12] = '{0, 0, 0, 0, 0, 0, 2, 2, 4, 4, 3, 3};
    int         wn_t [12] = '{40, 40, 40, 40, 350, 700, 1000, 2000, 2048, 2048, 4000, 8000};
    int         ex_t [12] = '{20, 10, 20, 10, 49, 49, 10, 10, 8, 4, 4, 4};
    logic       ref_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       sleep_req = 1'b0;
    logic       kick_req = 1'b0;
    logic       modulator_on = 1'b0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       core_sleep, dog_kick_instruction, irq_req, dog_timeout_pulse, main_clock_en;
    logic       instr_clock_en, adc_sample_clock, timer_tick_clock, chopper_clock, beeper_clock;
    logic       bprev = 1'b0, cprev = 1'b0;
    logic [5:0] ev;
    logic [7:0] d;
    int         n, p;
    int         fails = 0;
    int         check_count = 0;
    int         seed = 32'h2FA9;
    assign ev = {dog_timeout_pulse, beeper_clock ^ bprev, chopper_clock ^ cprev,
                 adc_sample_clock, timer_tick_clock, instr_clock_en};
    // free-running reference clock
    always #5 ref_clk = ~ref_clk;
    // previous levels, so toggles count as events
    always @(posedge ref_clk)
    begin
        bprev <= beeper_clock;
        cprev <= chopper_clock;
    end
    ctw_clock_timer_watchdog #(.DOG_OSC_CYCLES(DOGC)) uut (.*);
    ctw_core_model u_core (.*);
    // checks, verdict, bus cycles, waits
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= {idx, 2'b00};
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task automatic kick();
        @(posedge ref_clk);
        kick_req <= 1'b1;
        @(posedge ref_clk);
        kick_req <= 1'b0;
    endtask
    task automatic await(input int k, input int lim);
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (ev[k] !== 1'b1 && n < lim);
        if (ev[k] !== 1'b1)
        begin
            fails++;
            $display("[FAIL] %0t wait ran out", $time);
            print_verdict();
        end
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        rc(8'h18, 8'h00);
        rc(8'h38, 8'h00);
        rc(8'h3C, 8'h80);
        rc(8'h50, 8'h00);
        rc(8'h54, 8'h00);
        rc(8'h34, 8'h00);
        rc(8'h08, 8'h00);
        rc(8'h3D, 8'h00);
        repeat (4)
        begin
            d = 8'($random(seed));
            wr(IDX_IRQ_ENABLES, d);
            rc(8'h1C, d);
        end
        wr(IDX_TIMER_COUNT, 8'hA5);
        rc(8'h38, 8'h00);
        // taps 0 to 3 each raise the flag on the tick that drops their bit
        for (int t = 0; t < 4; t++)
        begin
            wr(IDX_TIMER_CONTROL, 8'h00);
            wr(IDX_IRQ_FLAGS, 8'h00);
            wr(IDX_TIMER_CONTROL, 8'h88 | 8'(t));
            repeat ((2 << t) - 1) await(1, 1100);
            rc(8'h38, 8'((2 << t) - 1));
            rc(8'h18, 8'h00);
            await(1, 1100);
            rc(8'h18, 8'h10);
        end
        for (int e = 0; e < 4; e++)
        begin
            wr(IDX_IRQ_ENABLES, {e[1], 2'b00, e[0], 4'h0});
            @(negedge ref_clk);
            check({7'h00, irq_req}, {7'h00, e == 3});
        end
        wr(IDX_IRQ_FLAGS, 8'hFF);
        rc(8'h18, 8'h10);
        wr(IDX_TIMER_CONTROL, 8'h00);
        wr(IDX_IRQ_FLAGS, 8'h00);
        await(1, 1100);
        check({7'h00, irq_req}, 8'h00);
        rc(8'h38, 8'h00);
        // sleep a random while; the powerdown flag stays until cleared
        @(posedge ref_clk);
        sleep_req <= 1'b1;
        repeat (20 + ($random(seed) & 63)) @(posedge ref_clk);
        @(negedge ref_clk);
        check({7'h00, main_clock_en}, 8'h00);
        @(posedge ref_clk);
        sleep_req <= 1'b0;
        wr(IDX_CORE_STATUS, 8'hFF);
        rc(8'h10, 8'h10);
        wr(IDX_CORE_STATUS, 8'h00);
        rc(8'h10, 8'h00);
        // windows are whole periods, so counts do not depend on phase
        for (int i = 0; i < 12; i++)
        begin
            @(posedge ref_clk);
            modulator_on <= md_t[i][0];
            wr(IDX_MAIN_CLK_SEL, 8'(ms_t[i]));
            wr(IDX_PERIPH_CLK_SEL, 8'(ps_t[i]));
            repeat (wn_t[i] / 2) @(posedge ref_clk);
            n = 0;
            repeat (wn_t[i]) @(negedge ref_clk) n += ev[ev_t[i]];
            check(8'(n), 8'(ex_t[i]));
        end
        for (int c = 1; c >= 0; c--)
        begin
            wr(IDX_PERIPH_CLK_SEL, 8'(4 * c));
            repeat (3) @(negedge ref_clk);
            check({7'h00, chopper_clock}, 8'(c));
        end
        // a zero write cannot stop the watchdog; kicks hold it off
        wr(IDX_DOG_CONTROL, 8'h87);
        wr(IDX_DOG_CONTROL, 8'h07);
        rc(8'h34, 8'h87);
        repeat (4)
        begin
            repeat (500) @(posedge ref_clk);
            kick();
        end
        rc(8'h10, 8'h00);
        for (int b = 0; b < 3; b++)
        begin
            p = DOGC << (b + 1);
            wr(IDX_DOG_CONTROL, 8'(8'h87 - b));
            kick();
            await(5, 260 * p);
            check({7'h00, n >= 255 * p - 4 && n <= 257 * p}, 8'h01);
            rc(8'h10, 8'h08);
            wr(IDX_CORE_STATUS, 8'h00);
            rc(8'h10, 8'h00);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
